// file: rtl/pfp_pkg.sv
package pfp_pkg;

	// Mode selector patterns
	localparam logic [3:0] PFP_UPPER_ADDRESS_SELECT = 4'h4;
	localparam logic [3:0] PFP_DATA_SELECT = 4'h5;
	localparam logic [3:0] PFP_COMMAND_SELECT_MODE = 4'h8;

	// Command words carried on the data bus in command mode
	localparam logic [15:0] PFP_READ_CMD = 16'h0011;
	localparam logic [15:0] PFP_PAGE_WRITE_CMD = 16'h0012;
	localparam logic [15:0] PFP_PAGE_WRITE_LOCK_CMD = 16'h0022;
	localparam logic [15:0] PFP_ERASE_THEN_WRITE_CMD = 16'h0032;
	localparam logic [15:0] PFP_ERASE_WRITE_LOCK_CMD = 16'h0042;
	localparam logic [15:0] PFP_FULL_ERASE_CMD = 16'h0013;
	localparam logic [15:0] PFP_LOCK_SET_CMD = 16'h0014;
	localparam logic [15:0] PFP_LOCK_REMOVE_CMD = 16'h0024;
	localparam logic [15:0] PFP_LOCK_QUERY_CMD = 16'h0015;
	localparam logic [15:0] PFP_NVM_FLAG_SET_CMD = 16'h0034;
	localparam logic [15:0] PFP_NVM_FLAG_REMOVE_CMD = 16'h0044;
	localparam logic [15:0] PFP_NVM_FLAG_QUERY_CMD = 16'h0025;
	localparam logic [15:0] PFP_SECURITY_SET_CMD = 16'h0054;
	localparam logic [15:0] PFP_SECURITY_QUERY_CMD = 16'h0035;
	localparam logic [15:0] PFP_MEMORY_WRITE_CMD = 16'h001F;
	localparam logic [15:0] PFP_VERSION_QUERY_CMD = 16'h001E;

	// Values after reset
	localparam logic [15:0] PFP_WORD_RESET = 16'h0000;

	typedef enum logic [4:0] {
		PFP_OP_NONE = 5'h00,
		PFP_OP_READ = 5'h01,
		PFP_OP_PAGE_WRITE = 5'h02,
		PFP_OP_PAGE_WRITE_LOCK = 5'h03,
		PFP_OP_ERASE_THEN_WRITE = 5'h04,
		PFP_OP_ERASE_WRITE_LOCK = 5'h05,
		PFP_OP_FULL_ERASE = 5'h06,
		PFP_OP_LOCK_SET = 5'h07,
		PFP_OP_LOCK_REMOVE = 5'h08,
		PFP_OP_LOCK_QUERY = 5'h09,
		PFP_OP_NVM_FLAG_SET = 5'h0A,
		PFP_OP_NVM_FLAG_REMOVE = 5'h0B,
		PFP_OP_NVM_FLAG_QUERY = 5'h0C,
		PFP_OP_SECURITY_SET = 5'h0D,
		PFP_OP_SECURITY_QUERY = 5'h0E,
		PFP_OP_MEMORY_WRITE = 5'h0F,
		PFP_OP_VERSION_QUERY = 5'h10
	} pfp_op_t;

	typedef enum logic [1:0] {
		PFP_ST_IDLE = 2'b00,
		PFP_ST_EXEC = 2'b01
	} pfp_state_t;

endpackage : pfp_pkg

// file: rtl/pfp_port.sv
`timescale 1ns/1ps

// Function
// - Mode 0100 targets the upper address register, 0101 the data register, 1000 the command word, other codes no register.
// - In command mode the 16-bit data bus value is stored as the new command word.
// - Codes 0x0011, 0x0012 and 0x0022 decode to read, page write and page write with lock.
// - Codes 0x0032, 0x0042 and 0x0013 decode to erase-write, erase-write-lock and full erase.
// - Codes 0x0014, 0x0024 and 0x0015 decode to lock set, lock remove and lock query.
// - Codes 0x0034, 0x0044 and 0x0025 decode to non-volatile flag set, remove and query.
// - Codes 0x0054 and 0x0035 decode to security set and security query.
// - Codes 0x001F and 0x001E decode to memory write and version query.
// - An operation ends only once both the strobe and ready are high again.
// - On a low strobe the device latches mode and data and drops ready in the same cycle.
// - The device executes the command and raises ready only after it is done and the strobe is high.
module pfp_port (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [3:0] MODE,
	input wire logic [15:0] DATA_IN,
	input wire logic COMMAND_STROBE_N,
	output logic READY,
	output logic [15:0] DATA_OUT,
	output logic DATA_OE,
	output logic FLASH_REQ,
	output pfp_pkg::pfp_op_t FLASH_OP,
	output logic [15:0] FLASH_ADDR_HI,
	output logic [15:0] FLASH_WDATA,
	output logic [15:0] COMMAND_WORD,
	input wire logic FLASH_DONE,
	input wire logic [15:0] FLASH_RDATA
);
	import pfp_pkg::*;

	typedef struct packed {
		pfp_state_t state;
		logic ready;
		logic pending;
		logic flash_req;
		pfp_op_t op;
		logic [15:0] cmd;
		logic [15:0] addr_hi;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic oe;
	} pfp_regs_t;

	localparam pfp_regs_t REGS_RESET = '{
		state: PFP_ST_IDLE,
		ready: 1'b0,
		pending: 1'b0,
		flash_req: 1'b0,
		op: PFP_OP_NONE,
		cmd: PFP_WORD_RESET,
		addr_hi: PFP_WORD_RESET,
		wdata: PFP_WORD_RESET,
		rdata: PFP_WORD_RESET,
		oe: 1'b0
	};

	pfp_regs_t regs_reg;
	pfp_regs_t regs_next;
	logic [3:0] mode_s;
	logic [15:0] data_s;
	logic strobe_n_s;

	// Unlisted words decode to no action and still finish the handshake
	function automatic pfp_op_t decode_cmd(input logic [15:0] word);
		pfp_op_t op;
		case (word)
			PFP_READ_CMD: op = PFP_OP_READ;
			PFP_PAGE_WRITE_CMD: op = PFP_OP_PAGE_WRITE;
			PFP_PAGE_WRITE_LOCK_CMD: op = PFP_OP_PAGE_WRITE_LOCK;
			PFP_ERASE_THEN_WRITE_CMD: op = PFP_OP_ERASE_THEN_WRITE;
			PFP_ERASE_WRITE_LOCK_CMD: op = PFP_OP_ERASE_WRITE_LOCK;
			PFP_FULL_ERASE_CMD: op = PFP_OP_FULL_ERASE;
			PFP_LOCK_SET_CMD: op = PFP_OP_LOCK_SET;
			PFP_LOCK_REMOVE_CMD: op = PFP_OP_LOCK_REMOVE;
			PFP_LOCK_QUERY_CMD: op = PFP_OP_LOCK_QUERY;
			PFP_NVM_FLAG_SET_CMD: op = PFP_OP_NVM_FLAG_SET;
			PFP_NVM_FLAG_REMOVE_CMD: op = PFP_OP_NVM_FLAG_REMOVE;
			PFP_NVM_FLAG_QUERY_CMD: op = PFP_OP_NVM_FLAG_QUERY;
			PFP_SECURITY_SET_CMD: op = PFP_OP_SECURITY_SET;
			PFP_SECURITY_QUERY_CMD: op = PFP_OP_SECURITY_QUERY;
			PFP_MEMORY_WRITE_CMD: op = PFP_OP_MEMORY_WRITE;
			PFP_VERSION_QUERY_CMD: op = PFP_OP_VERSION_QUERY;
			default: op = PFP_OP_NONE;
		endcase
		return op;
	endfunction : decode_cmd

	// Read and query commands leave a result for the programmer to fetch
	function automatic logic returns_data(input pfp_op_t op);
		logic r;
		case (op)
			PFP_OP_READ, PFP_OP_LOCK_QUERY, PFP_OP_NVM_FLAG_QUERY,
			PFP_OP_SECURITY_QUERY, PFP_OP_VERSION_QUERY: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : returns_data

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation; mode and data are sampled through the same depth as the
	// strobe, so they are settled when the synchronised strobe falls.
	// Separate banks keep the strobe's idle-high reset apart from the buses

	pfp_sync #(
		.WIDTH(4),
		.RESET_VALUE(4'h0)
	) u_sync_mode (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.async_in(MODE),
		.sync_out(mode_s)
	);

	pfp_sync #(
		.WIDTH(16),
		.RESET_VALUE(PFP_WORD_RESET)
	) u_sync_data (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.async_in(DATA_IN),
		.sync_out(data_s)
	);

	pfp_sync #(
		.WIDTH(1),
		.RESET_VALUE(1'b1)
	) u_sync_strobe (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.async_in(COMMAND_STROBE_N),
		.sync_out(strobe_n_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Handshake sequencer

	always_comb begin
		pfp_op_t new_op;
		new_op = decode_cmd(data_s);
		regs_next = regs_reg;
		regs_next.flash_req = 1'b0;
		case (regs_reg.state)
			PFP_ST_IDLE: begin
				regs_next.ready = 1'b1;
				// Strobe low while ready: latch and acknowledge
				if (!strobe_n_s && regs_reg.ready) begin
					regs_next.ready = 1'b0;
					regs_next.state = PFP_ST_EXEC;
					case (mode_s)
						PFP_UPPER_ADDRESS_SELECT: regs_next.addr_hi = data_s;
						PFP_DATA_SELECT: begin
							regs_next.wdata = data_s;
							// Stays armed after a query, so repeated data reads return
							// the same result until the next command
							regs_next.oe = returns_data(regs_reg.op);
						end
						PFP_COMMAND_SELECT_MODE: begin
							regs_next.cmd = data_s;
							regs_next.op = new_op;
							if (new_op != PFP_OP_NONE) begin
								regs_next.flash_req = 1'b1;
								regs_next.pending = 1'b1;
							end
						end
						default: begin
						end
					endcase
				end
			end
			PFP_ST_EXEC: begin
				regs_next.ready = 1'b0;
				// Result kept for any finished action; only reads and queries expose it
				if (regs_reg.pending && FLASH_DONE) begin
					regs_next.pending = 1'b0;
					regs_next.rdata = FLASH_RDATA;
				end
				if (strobe_n_s) begin
					regs_next.oe = 1'b0;
				end
				// Ready only once the command is done and the strobe is back high
				if (strobe_n_s && !(regs_reg.pending && !FLASH_DONE)) begin
					regs_next.ready = 1'b1;
					regs_next.state = PFP_ST_IDLE;
				end
			end
			default: begin
				regs_next = REGS_RESET;
			end
		endcase
	end

	// Reset forces ready low, so no handshake can start during reset
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			regs_reg <= REGS_RESET;
		end else begin
			regs_reg <= regs_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	// All outputs come straight from the state register

	assign READY = regs_reg.ready;
	assign DATA_OUT = regs_reg.rdata;
	assign DATA_OE = regs_reg.oe;
	assign FLASH_REQ = regs_reg.flash_req;
	assign FLASH_OP = regs_reg.op;
	assign FLASH_ADDR_HI = regs_reg.addr_hi;
	assign FLASH_WDATA = regs_reg.wdata;
	assign COMMAND_WORD = regs_reg.cmd;

endmodule : pfp_port

// file: rtl/pfp_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for pins coming from the programmer
module pfp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : pfp_sync

// file: testbench/pfp_port_asserts.sv
`timescale 1ns/1ps
module pfp_port_asserts (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [3:0] MODE,
	input wire logic [15:0] DATA_IN,
	input wire logic COMMAND_STROBE_N,
	input wire logic READY,
	input wire logic DATA_OE,
	input wire logic FLASH_REQ,
	input wire logic [15:0] FLASH_ADDR_HI,
	input wire logic [15:0] FLASH_WDATA,
	input wire logic [15:0] COMMAND_WORD
);
	import pfp_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	strobe_ack_a: assert property (READY && $fell(COMMAND_STROBE_N) |-> ##[1:3] !READY)
		else $error("ready not dropped");
	ready_wait_a: assert property (!READY && !COMMAND_STROBE_N |=> !READY)
		else $error("ready high under low strobe");
	ready_rise_a: assert property ($rose(READY) |-> COMMAND_STROBE_N && $past(COMMAND_STROBE_N))
		else $error("ready rose early");
	req_pulse_a: assert property (FLASH_REQ |=> !FLASH_REQ)
		else $error("request too long");
	req_busy_a: assert property (FLASH_REQ |-> !READY)
		else $error("request while ready");
	no_cmd_a: assert property ($fell(READY) && MODE != PFP_COMMAND_SELECT_MODE |-> !FLASH_REQ)
		else $error("request outside command mode");
	cmd_store_a: assert property ($fell(READY) && MODE == PFP_COMMAND_SELECT_MODE
		|-> COMMAND_WORD == DATA_IN) else $error("command word lost");
	addr_store_a: assert property ($fell(READY) && MODE == 4'h4 |-> FLASH_ADDR_HI == DATA_IN)
		else $error("address lost");
	data_store_a: assert property ($fell(READY) && MODE == 4'h5 |-> FLASH_WDATA == DATA_IN)
		else $error("data lost");
	addr_keep_a: assert property ($fell(READY) && MODE != PFP_UPPER_ADDRESS_SELECT
		|-> $stable(FLASH_ADDR_HI)) else $error("address changed by other mode");
	data_keep_a: assert property ($fell(READY) && MODE != PFP_DATA_SELECT
		|-> $stable(FLASH_WDATA)) else $error("data changed by other mode");
	cmd_keep_a: assert property ($fell(READY) && MODE != PFP_COMMAND_SELECT_MODE
		|-> $stable(COMMAND_WORD)) else $error("command changed by other mode");
	oe_latch_a: assert property ($rose(DATA_OE) |-> !READY)
		else $error("bus driven while ready");
endmodule : pfp_port_asserts

// file: testbench/pfp_prog.sv
`timescale 1ns/1ps
module pfp_prog (
	input wire logic clk,
	input wire logic ready,
	output logic [3:0] mode,
	output logic [15:0] data,
	output logic strobe_n
);
	initial begin
		mode = 4'h0;
		data = 16'h0000;
		strobe_n = 1'b1;
	end
	int stalls = 0;
	// Bounded waits; every wait that runs out is counted as a stall
	task automatic xfer(input logic [3:0] m, input logic [15:0] d, input int slow);
		for (int n = 0; n < 300 && ready !== 1'b1; n++) @(posedge clk);
		if (ready !== 1'b1) stalls++;
		mode <= m;
		data <= d;
		@(posedge clk);
		strobe_n <= 1'b0;
		for (int n = 0; n < 300 && ready !== 1'b0; n++) @(posedge clk);
		if (ready !== 1'b0) stalls++;
		// Released bus shows the inverse, never a stale copy
		mode <= ~m;
		data <= ~d;
		repeat (slow) @(posedge clk);
		strobe_n <= 1'b1;
		for (int n = 0; n < 300 && ready !== 1'b1; n++) @(posedge clk);
		if (ready !== 1'b1) stalls++;
	endtask : xfer
endmodule : pfp_prog

// file: testbench/tb_pfp_port.sv
`timescale 1ns/1ps
module tb_pfp_port;
	import pfp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] mode;
	logic [15:0] din, dout, addr, wd, cw, rd = 16'h0000;
	logic strobe_n, ready, oe, req, done = 1'b0;
	pfp_op_t op;
	pfp_op_t opq[$];
	logic [15:0] dq[$];
	logic [31:0] seed = 32'hDA6AA7EB;
	logic [31:0] rs = 32'hDA6AA7EB;
	logic [15:0] qmask = 16'hA901;
	logic [15:0] codes [16] = '{16'h0011, 16'h0012, 16'h0022, 16'h0032, 16'h0042, 16'h0013,
		16'h0014, 16'h0024, 16'h0015, 16'h0034, 16'h0044, 16'h0025, 16'h0054, 16'h0035,
		16'h001F, 16'h001E};
	int pend = 0;
	logic isq = 1'b0;
	logic oe_q = 1'b0;
	int bad_count = 0;
	int checks = 0;
	always #20 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	pfp_port uut (.CORE_CLK(clk), .RST_N(rst_n), .MODE(mode), .DATA_IN(din),
		.COMMAND_STROBE_N(strobe_n), .READY(ready), .DATA_OUT(dout), .DATA_OE(oe),
		.FLASH_REQ(req), .FLASH_OP(op), .FLASH_ADDR_HI(addr), .FLASH_WDATA(wd),
		.COMMAND_WORD(cw), .FLASH_DONE(done), .FLASH_RDATA(rd));
	pfp_prog prog (.clk(clk), .ready(ready), .mode(mode), .data(din), .strobe_n(strobe_n));
	task automatic stop_test;
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	// Flash side: answers each request after one to four cycles
	always @(posedge clk) begin
		oe_q <= oe;
		done <= (pend == 1);
		if (pend > 0) begin
			pend <= pend - 1;
			if (pend == 1) begin
				rs = xs(rs);
				rd <= rs[15:0];
				if (isq) dq.push_back(rs[15:0]);
			end
		end
		if (req === 1'b1) begin
			if (opq.size() == 0) cmp(16'(op), 16'hFFFF);
			else begin
				isq = qmask[opq[0] - 1];
				cmp(16'(op), 16'(opq.pop_front()));
			end
			pend <= 1 + rs[1:0];
		end
		if (oe === 1'b1 && oe_q === 1'b0 && dq.size() > 0) cmp(dout, dq.pop_front());
	end
	initial begin
		repeat (10) @(posedge clk);
		cmp(addr | wd | cw | dout | 16'(ready) | 16'(oe) | 16'(req) | 16'(op), 16'h0000);
		rst_n <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			seed = xs(seed);
			prog.xfer(4'h4, seed[15:0], seed[17:16]);
			prog.xfer(4'h5, seed[31:16], 0);
			if (i < 16) opq.push_back(pfp_op_t'(i + 1));
			prog.xfer(4'h8, i < 16 ? codes[i] : 16'h0099, seed[19:18]);
			if (i < 16 && qmask[i]) prog.xfer(4'h5, 16'h0000, 0);
			prog.xfer({2'b11, seed[21:20]}, seed[15:0], 0);
		end
		repeat (4) @(posedge clk);
		cmp(16'(opq.size() + dq.size()), 16'h0000);
		cmp(16'(prog.stalls), 16'h0000);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end
endmodule : tb_pfp_port
bind pfp_port pfp_port_asserts chk (
	.CORE_CLK(CORE_CLK),
	.RST_N(RST_N),
	.MODE(MODE),
	.DATA_IN(DATA_IN),
	.COMMAND_STROBE_N(COMMAND_STROBE_N),
	.READY(READY),
	.DATA_OE(DATA_OE),
	.FLASH_REQ(FLASH_REQ),
	.FLASH_ADDR_HI(FLASH_ADDR_HI),
	.FLASH_WDATA(FLASH_WDATA),
	.COMMAND_WORD(COMMAND_WORD)
);
